// File: shared/mem_if.sv
// Port bundle between the serial engine and its byte memory
`timescale 1ns/10ps
interface mem_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic we;
  logic [7:0] rdata;
  modport ctrl(output addr, output wdata, output we, input rdata);
  modport mem(input addr, input wdata, input we, output rdata);
endinterface

// File: shared/mgmt_pkg.sv
// Constants and types shared by the management interface files
package mgmt_pkg;
  // Two-wire bus device address (7-bit); plain default
  localparam logic [6:0] DEV_ADDR = 7'h50;
  // Memory geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 256;
  // Live monitor map (read only)
  localparam logic [7:0] ADDR_TEMP = 8'h00;
  localparam logic [7:0] ADDR_BIAS = 8'h01;
  localparam logic [7:0] ADDR_TXPOW = 8'h02;
  localparam logic [7:0] ADDR_RXPOW = 8'h03;
  localparam logic [7:0] ADDR_VCC = 8'h04;
  localparam logic [7:0] ADDR_ALARM = 8'h05;
  localparam logic [7:0] ADDR_WARN = 8'h06;
  localparam logic [7:0] ADDR_STATUS = 8'h07;
  // First location that the host may write
  localparam logic [7:0] WRITABLE_BASE = 8'h20;
  // Number of monitored quantities
  localparam int NUM_MON = 5;
  // Factory limits, index 0 temp, 1 bias, 2 tx power, 3 rx power, 4 vcc
  localparam logic [4:0][7:0] ALARM_HI = {8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hF0};
  localparam logic [4:0][7:0] WARN_HI = {8'hE0, 8'hE0, 8'hE0, 8'hE0, 8'hE0};
  localparam logic [4:0][7:0] WARN_LO = {8'h20, 8'h20, 8'h20, 8'h20, 8'h20};
  localparam logic [4:0][7:0] ALARM_LO = {8'h10, 8'h10, 8'h10, 8'h10, 8'h10};
  // Synchronised pin positions
  localparam int PIN_MODSEL_N = 5;
  localparam int PIN_LASER_OFF = 4;
  localparam int PIN_PDOWN = 3;
  localparam int PIN_SCL = 2;
  localparam int PIN_SDA = 1;
  localparam int PIN_SIGDET = 0;
  localparam int NUM_PINS = 6;
  // Serial engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_TXACK = 3'b100,
    ST_TXNEXT = 3'b101
  } serial_state_e;
  // Meaning of the byte being received
  typedef enum logic [1:0] {
    KIND_DEV = 2'b00,
    KIND_REG = 2'b01,
    KIND_DATA = 2'b10
  } byte_kind_e;
endpackage

// File: src/mgmt_mem.sv
// Byte memory for the writable management area, registered read
`timescale 1ns/10ps
module mgmt_mem (
  input wire logic clk_i,
  mem_if.mem bus
);
  logic [mgmt_pkg::DATA_W-1:0] store [mgmt_pkg::MEM_DEPTH];

  // Write on strobe, read data always from a register
  always_ff @(posedge clk_i) begin
    if (bus.we) begin
      store[bus.addr] <= bus.wdata;
    end
    bus.rdata <= store[bus.addr];
  end
endmodule

// File: src/optical_module_mgmt_interface.sv
// Management side of a pluggable optical module: pins, monitor, serial bus
`timescale 1ns/10ps
module optical_module_mgmt_interface (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mod_select_n_i,
  input wire logic laser_off_request_i,
  input wire logic power_down_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic signal_detect_i,
  input wire logic [39:0] monitor_i,
  output logic interrupt_n_o,
  output logic module_absent_o,
  output logic rx_signal_lost_o,
  output logic laser_enable_o,
  output logic standby_o
);
  logic [mgmt_pkg::NUM_PINS-1:0] pin_raw;
  logic [mgmt_pkg::NUM_PINS-1:0] sync1;
  logic [mgmt_pkg::NUM_PINS-1:0] sync2;
  logic [mgmt_pkg::NUM_PINS-1:0] sync3;
  logic soft_rst;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic selected;
  logic sda_bit;
  mgmt_pkg::serial_state_e state;
  mgmt_pkg::byte_kind_e kind;
  logic [2:0] bitcnt;
  logic [6:0] shift;
  logic [7:0] ptr;
  logic rw;
  logic ack;
  logic ack_on;
  logic sda_low;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;
  logic [4:0][7:0] live;
  logic [4:0] alarm_now;
  logic [4:0] warn_now;
  logic [4:0] alarm_latch;
  logic [4:0] warn_latch;
  logic live_ok;
  logic [7:0] status_byte;
  logic read_done;
  logic write_hit;
  mem_if mbus ();

  // Writable-area check used by write strobe and read mux
  function automatic logic is_writable(input logic [7:0] a);
    return a >= mgmt_pkg::WRITABLE_BASE;
  endfunction

  assign pin_raw = {mod_select_n_i, laser_off_request_i, power_down_i,
                    scl_i, sda_i, signal_detect_i};

  // Two-flop synchronisers plus one stage for edge detection
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Power-down falling edge acts as a full reset pulse
  assign soft_rst = !rst_n_i ||
    (sync3[mgmt_pkg::PIN_PDOWN] && !sync2[mgmt_pkg::PIN_PDOWN]);
  assign standby_o = sync2[mgmt_pkg::PIN_PDOWN];

  // Bus events from the host clock and data
  assign selected = !sync2[mgmt_pkg::PIN_MODSEL_N];
  assign sda_bit = sync2[mgmt_pkg::PIN_SDA];
  assign scl_rise = sync2[mgmt_pkg::PIN_SCL] && !sync3[mgmt_pkg::PIN_SCL];
  assign scl_fall = !sync2[mgmt_pkg::PIN_SCL] && sync3[mgmt_pkg::PIN_SCL];
  assign start_seen = sync2[mgmt_pkg::PIN_SCL] && sync3[mgmt_pkg::PIN_SCL] &&
    !sda_bit && sync3[mgmt_pkg::PIN_SDA];
  assign stop_seen = sync2[mgmt_pkg::PIN_SCL] && sync3[mgmt_pkg::PIN_SCL] &&
    sda_bit && !sync3[mgmt_pkg::PIN_SDA];
  assign rx_byte = {shift, sda_bit};

  // Open-drain data pin: only ever pulled low; clock pin is input only
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_low && selected;

  // Read source: live monitor block below the writable area
  assign status_byte = {5'h00, sync2[mgmt_pkg::PIN_LASER_OFF],
                        standby_o, rx_signal_lost_o};
  always_comb begin
    unique case (ptr)
      mgmt_pkg::ADDR_TEMP: rd_byte = live[0];
      mgmt_pkg::ADDR_BIAS: rd_byte = live[1];
      mgmt_pkg::ADDR_TXPOW: rd_byte = live[2];
      mgmt_pkg::ADDR_RXPOW: rd_byte = live[3];
      mgmt_pkg::ADDR_VCC: rd_byte = live[4];
      mgmt_pkg::ADDR_ALARM: rd_byte = {3'h0, alarm_latch};
      mgmt_pkg::ADDR_WARN: rd_byte = {3'h0, warn_latch};
      mgmt_pkg::ADDR_STATUS: rd_byte = status_byte;
      default: rd_byte = is_writable(ptr) ? mbus.rdata : 8'h00;
    endcase
  end

  // Memory port: byte writes go only to unprotected locations
  assign write_hit = (state == mgmt_pkg::ST_RX) && scl_rise &&
    (bitcnt == 3'h7) && (kind == mgmt_pkg::KIND_DATA) && selected;
  assign mbus.addr = ptr;
  assign mbus.wdata = rx_byte;
  assign mbus.we = write_hit && is_writable(ptr);
  assign read_done = (state == mgmt_pkg::ST_TX) && scl_rise &&
    (bitcnt == 3'h7);

  // Serial engine: sample on rising clock, drive on falling clock
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      state <= mgmt_pkg::ST_IDLE;
      kind <= mgmt_pkg::KIND_DEV;
      bitcnt <= 3'h0;
      shift <= 7'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      ack <= 1'b0;
      ack_on <= 1'b0;
      sda_low <= 1'b0;
    end else if (!selected) begin
      state <= mgmt_pkg::ST_IDLE;
      sda_low <= 1'b0;
    end else if (start_seen) begin
      state <= mgmt_pkg::ST_RX;
      kind <= mgmt_pkg::KIND_DEV;
      bitcnt <= 3'h0;
      sda_low <= 1'b0;
    end else if (stop_seen) begin
      state <= mgmt_pkg::ST_IDLE;
      sda_low <= 1'b0;
    end else begin
      unique case (state)
        mgmt_pkg::ST_IDLE: begin
          sda_low <= 1'b0;
        end
        mgmt_pkg::ST_RX: begin
          if (scl_rise) begin
            shift <= rx_byte[6:0];
            bitcnt <= bitcnt + 3'h1;
            if (bitcnt == 3'h7) begin
              state <= mgmt_pkg::ST_ACK;
              ack_on <= 1'b0;
              ack <= 1'b1;
              unique case (kind)
                mgmt_pkg::KIND_DEV: begin
                  ack <= (shift == mgmt_pkg::DEV_ADDR);
                  rw <= sda_bit;
                  kind <= mgmt_pkg::KIND_REG;
                end
                mgmt_pkg::KIND_REG: begin
                  ptr <= rx_byte;
                  kind <= mgmt_pkg::KIND_DATA;
                end
                default: begin
                  ptr <= ptr + 8'h01;
                end
              endcase
            end
          end
        end
        mgmt_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (!ack_on) begin
              ack_on <= 1'b1;
              sda_low <= ack;
            end else begin
              ack_on <= 1'b0;
              bitcnt <= 3'h0;
              if (!ack) begin
                state <= mgmt_pkg::ST_IDLE;
                sda_low <= 1'b0;
              end else if (rw && kind == mgmt_pkg::KIND_REG) begin
                state <= mgmt_pkg::ST_TX;
                sda_low <= !rd_byte[7];
              end else begin
                state <= mgmt_pkg::ST_RX;
                sda_low <= 1'b0;
              end
            end
          end
        end
        mgmt_pkg::ST_TX: begin
          if (scl_rise) begin
            bitcnt <= bitcnt + 3'h1;
            if (bitcnt == 3'h7) begin
              state <= mgmt_pkg::ST_TXACK;
              ptr <= ptr + 8'h01;
            end
          end else if (scl_fall) begin
            sda_low <= !rd_byte[3'h7 - bitcnt];
          end
        end
        mgmt_pkg::ST_TXACK: begin
          if (scl_fall) begin
            sda_low <= 1'b0;
          end else if (scl_rise) begin
            state <= sda_bit ? mgmt_pkg::ST_IDLE : mgmt_pkg::ST_TXNEXT;
          end
        end
        mgmt_pkg::ST_TXNEXT: begin
          if (scl_fall) begin
            state <= mgmt_pkg::ST_TX;
            bitcnt <= 3'h0;
            sda_low <= !rd_byte[7];
          end
        end
        default: begin
          state <= mgmt_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Limit comparison, held off until a first value is captured
  genvar g;
  generate
    for (g = 0; g < mgmt_pkg::NUM_MON; g++) begin : g_lim
      assign alarm_now[g] = live_ok && ((live[g] > mgmt_pkg::ALARM_HI[g]) ||
        (live[g] < mgmt_pkg::ALARM_LO[g]));
      assign warn_now[g] = live_ok && ((live[g] > mgmt_pkg::WARN_HI[g]) ||
        (live[g] < mgmt_pkg::WARN_LO[g]));
    end
  endgenerate

  // Monitor capture, frozen in standby; flags sticky, cleared on read
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      live <= '0;
      live_ok <= 1'b0;
      alarm_latch <= 5'h00;
      warn_latch <= 5'h00;
    end else begin
      if (!standby_o) begin
        live <= monitor_i;
        live_ok <= 1'b1;
      end
      if (read_done && ptr == mgmt_pkg::ADDR_ALARM) begin
        alarm_latch <= alarm_now;
      end else begin
        alarm_latch <= alarm_latch | alarm_now;
      end
      if (read_done && ptr == mgmt_pkg::ADDR_WARN) begin
        warn_latch <= warn_now;
      end else begin
        warn_latch <= warn_latch | warn_now;
      end
    end
  end

  // Pin outputs
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      interrupt_n_o <= 1'b1;
      rx_signal_lost_o <= 1'b1;
      laser_enable_o <= 1'b0;
    end else begin
      interrupt_n_o <= !(|alarm_latch || |warn_latch);
      rx_signal_lost_o <= !sync2[mgmt_pkg::PIN_SIGDET];
      laser_enable_o <= !sync2[mgmt_pkg::PIN_LASER_OFF] && !standby_o;
    end
  end
  assign module_absent_o = 1'b0;

  mgmt_mem u_mem (
    .clk_i(clk_i),
    .bus(mbus.mem)
  );
endmodule

// File: test/host_master.sv
// Behavioural two-wire host that clocks and frames transfers
`timescale 1ns/10ps
module host_master (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // Clock stands high between frames; only the host drives it
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Quarter of a 160 ns serial clock period
  task automatic q();
    repeat (2) @(posedge clk_i);
  endtask
  // Start or repeated start: data falls with clock high
  task automatic start();
    q();
    sda_low_o <= 1'b0;
    q();
    scl_o <= 1'b1;
    q();
    sda_low_o <= 1'b1;
    q();
    scl_o <= 1'b0;
  endtask
  // Stop: data rises with clock high, then line stays released
  task automatic stop();
    q();
    sda_low_o <= 1'b1;
    q();
    scl_o <= 1'b1;
    q();
    sda_low_o <= 1'b0;
    q();
  endtask
  // One bit; a one releases the line, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    q();
    sda_low_o <= !b;
    q();
    scl_o <= 1'b1;
    q();
    r = sda_i;
    q();
    scl_o <= 1'b0;
  endtask
  // Byte MSB first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] d, input logic ack,
                         output logic [7:0] rx, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      rx[i] = r;
    end
    bit_io(ack, a);
  endtask
endmodule

// File: test/mgmt_monitor.sv
// Checker of the pin rules of the management interface
`timescale 1ns/10ps
module mgmt_monitor (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mod_select_n_i,
  input wire logic laser_off_request_i,
  input wire logic power_down_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic signal_detect_i,
  input wire logic [39:0] monitor_i,
  input wire logic interrupt_n_o,
  input wire logic module_absent_o,
  input wire logic rx_signal_lost_o,
  input wire logic laser_enable_o,
  input wire logic standby_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Constant pins
  AST_ABSENT: assert property (module_absent_o == 1'b0)
    else $error("module absent not low");
  AST_SDA_ZERO: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  // Pin follows its input after the sync delay
  AST_DESEL: assert property (
    mod_select_n_i [*5] |-> !sda_oe_o)
    else $error("data line pulled while deselected");
  AST_LOS_SET: assert property (
    (!signal_detect_i) [*5] |-> rx_signal_lost_o)
    else $error("loss of signal not flagged");
  AST_LOS_CLR: assert property (
    (signal_detect_i && !power_down_i) [*8] |-> !rx_signal_lost_o)
    else $error("loss of signal flagged with light");
  AST_STANDBY: assert property (
    power_down_i [*5] |-> standby_o && !laser_enable_o)
    else $error("standby not held");
  AST_LASER_OFF: assert property (
    laser_off_request_i [*5] |-> !laser_enable_o)
    else $error("laser on while off requested");
  AST_LASER_ON: assert property (
    (!laser_off_request_i && !power_down_i) [*8] |-> laser_enable_o)
    else $error("laser off without request");
  // Leaving standby resets the outputs within a few cycles
  AST_PDOWN: assert property (
    $fell(standby_o) |-> ##[0:3]
    (interrupt_n_o && rx_signal_lost_o && !sda_oe_o))
    else $error("no reset after power down");
  // Data is launched only in the clock low phase
  AST_OE_LAUNCH: assert property (
    $rose(sda_oe_o) |-> !$past(scl_i, 1) && !$past(scl_i, 2))
    else $error("data launched outside clock low");
endmodule
bind optical_module_mgmt_interface mgmt_monitor u_mon (.*);

// File: test/tb.sv
// Self-checking bench of the optical module management interface
`timescale 1ns/10ps
module tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sel_n = 1'b0, loff = 1'b0, pdown = 1'b0, sdet = 1'b1;
  logic [39:0] mon = {5{8'h80}};
  logic scl, sda_low, sda_o, sda_oe_o, int_n, absent, los, laser, stby;
  logic [7:0] ref_mem [0:255];
  logic [7:0] rx, v;
  logic a;
  logic [31:0] seed = 32'h143F6D67;
  int err_count = 0;
  int cmp_count = 0;
  // Open-drain line with pull-up
  wire sda = !(sda_low || (sda_oe_o && !sda_o));
  always #10 clk_i = ~clk_i;
  optical_module_mgmt_interface dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .mod_select_n_i(sel_n),
    .laser_off_request_i(loff), .power_down_i(pdown), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .signal_detect_i(sdet), .monitor_i(mon), .interrupt_n_o(int_n),
    .module_absent_o(absent), .rx_signal_lost_o(los),
    .laser_enable_o(laser), .standby_o(stby)
  );
  host_master host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
    .sda_low_o(sda_low));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [7:0] d, input logic ack_exp);
    host.byte_io(d, 1'b1, rx, a);
    chk(!a, ack_exp);
  endtask
  // Write n bytes from ad; only the writable area is kept by the model
  task automatic wr(input logic [7:0] ad, input int n);
    host.start();
    put({mgmt_pkg::DEV_ADDR, 1'b0}, 1'b1);
    put(ad, 1'b1);
    for (int i = 0; i < n; i++) begin
      v = 8'(rnd());
      if (ad >= mgmt_pkg::WRITABLE_BASE) ref_mem[ad] = v;
      put(v, 1'b1);
      ad++;
    end
    host.stop();
  endtask
  // Sequential read of n bytes from ad, last one not acknowledged
  task automatic rd(input logic [7:0] ad, input int n);
    host.start();
    put({mgmt_pkg::DEV_ADDR, 1'b0}, 1'b1);
    put(ad, 1'b1);
    host.start();
    put({mgmt_pkg::DEV_ADDR, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      host.byte_io(8'hFF, i == n - 1, rx, a);
      chk(rx, ref_mem[ad]);
      ad++;
    end
    host.stop();
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #500000;
    err_count++;
    give_verdict();
  end
  // Main sequence
  initial begin
    for (int i = 0; i < 32; i++) ref_mem[i] = 8'h00;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    for (int i = 0; i < 24; i++) begin
      {pdown, loff, sdet, sel_n} <= 4'(rnd());
      repeat (12) @(posedge clk_i);
      @(negedge clk_i);
      chk(laser, !loff && !pdown);
      chk(stby, pdown);
      chk(los, !sdet);
      chk(absent, 1'b0);
      @(posedge clk_i);
    end
    {pdown, loff, sdet, sel_n} <= 4'h2;
    repeat (12) @(posedge clk_i);
    chk(int_n, 1'b1);
    wr(8'h20, 4);
    wr(8'hFE, 3);
    wr(8'h1F, 2);
    rd(8'h1E, 6);
    rd(8'hFE, 2);
    mon[7:0] <= 8'hF5;
    repeat (8) @(posedge clk_i);
    chk(int_n, 1'b0);
    mon[7:0] <= 8'h80;
    // Status byte shows the laser-off request: {laser_off, standby, los}
    loff <= 1'b1;
    ref_mem[5] = 8'h01;
    ref_mem[6] = 8'h01;
    ref_mem[7] = 8'h04;
    rd(8'h05, 3);
    loff <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(int_n, 1'b1);
    for (int i = 0; i < 5; i++) begin
      v = 8'h20 + 8'(rnd() % 192);
      mon[8 * i +: 8] <= v;
      ref_mem[i] = v;
    end
    repeat (8) @(posedge clk_i);
    rd(8'h00, 5);
    sel_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    host.start();
    put({mgmt_pkg::DEV_ADDR, 1'b0}, 1'b0);
    host.stop();
    sel_n <= 1'b0;
    host.start();
    put({mgmt_pkg::DEV_ADDR, 1'b0}, 1'b1);
    pdown <= 1'b1;
    repeat (10) @(posedge clk_i);
    pdown <= 1'b0;
    repeat (12) @(posedge clk_i);
    rd(8'h20, 2);
    give_verdict();
  end
endmodule
